// *** core/iops_pin_select.v ***
// io port pin logic: latch, direction, open drain, analog read masking,
// change notification, weak pull-ups and peripheral input/output remapping
// assumes cpu register writes arrive as one-cycle strobes with data,
// and the pad ring resolves pin levels from the output enables
// How it works
// [R1] open-drain bit set: pin only pulled low, never driven high
// [R2] analog config resets to zero, all shared pins start analog
// [R3] port reads return zero for pins configured analog
// [R4] software sets direction input on analog pins
// [R5] software waits one cycle between port write and read
// [R6] change detect raises request with no clock, asynchronously
// [R7] up to 31 change inputs, each selectable as request source
// [R8] per-input enable bits in two registers gate the change request
// [R9] per-input weak pull-up enable bits in two registers
// [R10] software disables pull-ups on digital outputs
// [R11] remapping covers 26 pins numbered from zero
// [R12] each remappable input has a 5-bit pin select field
// [R13] input and output routing are independent
// [R14] software sets remapped input pins to input direction
// [R15] each remappable pin has a 5-bit output select field
// [R16] output code zero leaves the pin on ordinary port logic
// [R17] serial transmit code 00011, request-to-send code 00100
// [R18] sync serial data 00111, clock 01000, select 01001
// [R19] compare channel one 10010, channel two 10011
// [R20] fourteen remappable peripheral inputs
// [R21] direction one is input, zero output; all pins reset to input
// [R22] latch reads latch, port reads pins, either write loads latch
// [R23] request when an enabled input differs from its last sample

`timescale 1ns/1ps
`default_nettype none
`include "iops_consts.vh"

module iops_pin_select (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [25:0] LATCH_WDATA,
  input wire LATCH_WE,
  input wire [25:0] DIR_WDATA,
  input wire DIR_WE,
  input wire [25:0] ODSEL_WDATA,
  input wire ODSEL_WE,
  input wire [12:0] ANCFG_WDATA,
  input wire ANCFG_WE,
  input wire [30:0] CNEN_WDATA,
  input wire CNEN_WE,
  input wire [30:0] PU_WDATA,
  input wire PU_WE,
  input wire [4:0] OUTSEL_WDATA,
  input wire [4:0] OUTSEL_IDX,
  input wire OUTSEL_WE,
  input wire [4:0] INSEL_WDATA,
  input wire [3:0] INSEL_IDX,
  input wire INSEL_WE,
  input wire [25:0] PIN_IN,
  output wire [25:0] PIN_OUT,
  output wire [25:0] PIN_OE,
  input wire [30:0] CHANGE_WATCH_INPUT,
  output wire [30:0] WEAK_PULLUP_EN,
  output wire CHANGE_IRQ,
  output reg [25:0] OUTPUT_LATCH,
  output reg [25:0] PIN_DIRECTION,
  output reg [25:0] OPEN_DRAIN_SELECT,
  output reg [12:0] ANALOG_PIN_CONFIG,
  output reg [30:0] CHANGE_IRQ_ENABLE,
  output reg [25:0] PIN_LEVEL,
  input wire SERIAL_TX_OUT,
  input wire SERIAL_RTS_OUT,
  input wire SYNC_SERIAL_DATA_OUT,
  input wire SYNC_SERIAL_CLOCK_OUT,
  input wire SYNC_SERIAL_SELECT_OUT,
  input wire COMPARE_OUT_ONE,
  input wire COMPARE_OUT_TWO,
  output wire EXT_IRQ_ONE,
  output wire EXT_IRQ_TWO,
  output wire TIMER_TWO_CLOCK_IN,
  output wire TIMER_THREE_CLOCK_IN,
  output wire CAPTURE_IN_ONE,
  output wire CAPTURE_IN_TWO,
  output wire CAPTURE_IN_SEVEN,
  output wire CAPTURE_IN_EIGHT,
  output wire COMPARE_FAULT_IN,
  output wire SERIAL_RX_IN,
  output wire SERIAL_CTS_IN,
  output wire SYNC_SERIAL_DATA_IN,
  output wire SYNC_SERIAL_CLOCK_IN,
  output wire SYNC_SERIAL_SELECT_IN
);
  // ****************************************
  // configuration registers
  // ****************************************
  reg [30:0] pullup_ff;
  reg [30:0] cn_last_ff;
  reg [4:0] outsel_ff [0:`IOPS_NPIN-1];
  reg [4:0] insel_ff [0:`IOPS_NIN-1];
  integer i;

  // output latch: port writes and latch writes both land here
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      OUTPUT_LATCH <= `IOPS_LAT_RST;
    end else if (LATCH_WE) begin
      OUTPUT_LATCH <= LATCH_WDATA; // [R22]
    end
  end

  // direction: one means input, so reset leaves every pad undriven
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PIN_DIRECTION <= `IOPS_DIR_RST; // [R21]
    end else if (DIR_WE) begin
      PIN_DIRECTION <= DIR_WDATA; // [R21]
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      OPEN_DRAIN_SELECT <= `IOPS_OD_RST;
    end else if (ODSEL_WE) begin
      OPEN_DRAIN_SELECT <= ODSEL_WDATA; // [R1]
    end
  end

  // analog config: zero means analog, so the shared pins start analog
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ANALOG_PIN_CONFIG <= `IOPS_ANCFG_RST; // [R2]
    end else if (ANCFG_WE) begin
      ANALOG_PIN_CONFIG <= ANCFG_WDATA;
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      CHANGE_IRQ_ENABLE <= `IOPS_CNEN_RST;
    end else if (CNEN_WE) begin
      CHANGE_IRQ_ENABLE <= CNEN_WDATA; // [R8]
    end
  end

  // pull-ups: dropping them on digital outputs is left to software
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pullup_ff <= `IOPS_PU_RST;
    end else if (PU_WE) begin
      pullup_ff <= PU_WDATA; // [R9]
    end
  end

  // ****************************************
  // routing select registers
  // ****************************************
  // routing selects; index beyond the table is ignored
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      for (i = 0; i < `IOPS_NPIN; i = i + 1) begin
        outsel_ff[i] <= `IOPS_OUTSEL_RST;
      end
      for (i = 0; i < `IOPS_NIN; i = i + 1) begin
        insel_ff[i] <= `IOPS_INSEL_RST;
      end
    end else begin
      if (OUTSEL_WE && OUTSEL_IDX < 5'h1a) begin
        outsel_ff[OUTSEL_IDX] <= OUTSEL_WDATA; // [R15]
      end
      if (INSEL_WE && INSEL_IDX < 4'he) begin
        insel_ff[INSEL_IDX] <= INSEL_WDATA; // [R12] [R13]
      end
    end
  end

  assign WEAK_PULLUP_EN = pullup_ff; // [R9]

  // ****************************************
  // output mapping and pin drive
  // ****************************************
  // true for the seven codes that name a peripheral output;
  // used only for the pin mux select; periph_out decodes the same codes itself
  function oc_known;
    input [4:0] code;
    begin
      case (code)
        `IOPS_OC_SER_TX: oc_known = 1'b1;
        `IOPS_OC_SER_RTS: oc_known = 1'b1;
        `IOPS_OC_SS_DO: oc_known = 1'b1;
        `IOPS_OC_SS_CK: oc_known = 1'b1;
        `IOPS_OC_SS_SEL: oc_known = 1'b1;
        `IOPS_OC_CMP1: oc_known = 1'b1;
        `IOPS_OC_CMP2: oc_known = 1'b1;
        default: oc_known = 1'b0; // [R16]
      endcase
    end
  endfunction

  function periph_out;
    input [4:0] code;
    input [6:0] outs;
    begin
      case (code)
        `IOPS_OC_SER_TX: periph_out = outs[0]; // [R17]
        `IOPS_OC_SER_RTS: periph_out = outs[1]; // [R17]
        `IOPS_OC_SS_DO: periph_out = outs[2]; // [R18]
        `IOPS_OC_SS_CK: periph_out = outs[3]; // [R18]
        `IOPS_OC_SS_SEL: periph_out = outs[4]; // [R18]
        `IOPS_OC_CMP1: periph_out = outs[5]; // [R19]
        `IOPS_OC_CMP2: periph_out = outs[6]; // [R19]
        default: periph_out = 1'b0;
      endcase
    end
  endfunction

  wire [6:0] p_outs = {COMPARE_OUT_TWO, COMPARE_OUT_ONE, SYNC_SERIAL_SELECT_OUT,
    SYNC_SERIAL_CLOCK_OUT, SYNC_SERIAL_DATA_OUT, SERIAL_RTS_OUT, SERIAL_TX_OUT};
  wire [25:0] drive_val;

  genvar g;
  generate
    for (g = 0; g < `IOPS_NPIN; g = g + 1) begin : g_pin // [R11]
      // unknown codes are treated as null so the latch keeps the pin
      wire mapped = oc_known(outsel_ff[g]);
      assign drive_val[g] = mapped ? periph_out(outsel_ff[g], p_outs) :
        OUTPUT_LATCH[g]; // [R16]
      // open drain: only the low level is driven
      assign PIN_OUT[g] = OPEN_DRAIN_SELECT[g] ? 1'b0 : drive_val[g]; // [R1]
      assign PIN_OE[g] = !PIN_DIRECTION[g] &&
        (!OPEN_DRAIN_SELECT[g] || !drive_val[g]); // [R1] [R21]
    end
  endgenerate

  // ****************************************
  // port read with analog masking
  // ****************************************
  // low pins share the analog inputs; analog ones read zero
  wire [25:0] digital_mask = {13'h1fff, ANALOG_PIN_CONFIG}; // [R3]

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PIN_LEVEL <= `IOPS_LVL_RST;
    end else begin
      PIN_LEVEL <= PIN_IN & digital_mask; // [R3] [R22]
    end
  end

  // ****************************************
  // change notification
  // ****************************************
  // comparison is combinational so a change flags a request with no clock
  // limitation: a stopped clock freezes the last sample, so the request
  // holds until the clock returns and resamples
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cn_last_ff <= `IOPS_CNLAST_RST;
    end else begin
      cn_last_ff <= CHANGE_WATCH_INPUT; // [R23]
    end
  end

  assign CHANGE_IRQ = |((CHANGE_WATCH_INPUT ^ cn_last_ff) & CHANGE_IRQ_ENABLE); // [R6] [R7] [R23]

  // ****************************************
  // input mapping
  // ****************************************
  // pin number to level; numbers past the last pin are tied low,
  // which is where the all-ones reset select parks each input
  function route_pin;
    input [4:0] sel;
    input [25:0] pins;
    begin
      if (sel < `IOPS_NPIN) begin
        route_pin = pins[sel];
      end else begin
        route_pin = 1'b0;
      end
    end
  endfunction

  wire [13:0] routed;
  generate
    for (g = 0; g < `IOPS_NIN; g = g + 1) begin : g_in
      // codes above the last pin read as tied low
      assign routed[g] = route_pin(insel_ff[g], PIN_IN); // [R12]
    end
  endgenerate

  // ****************************************
  // peripheral input hookup
  // ****************************************
  assign EXT_IRQ_ONE = routed[`IOPS_IN_EXT_IRQ_ONE]; // [R20]
  assign EXT_IRQ_TWO = routed[`IOPS_IN_EXT_IRQ_TWO];
  assign TIMER_TWO_CLOCK_IN = routed[`IOPS_IN_TIMER_TWO_CLOCK_IN];
  assign TIMER_THREE_CLOCK_IN = routed[`IOPS_IN_TIMER_THREE_CLOCK_IN];
  assign CAPTURE_IN_ONE = routed[`IOPS_IN_CAP1];
  assign CAPTURE_IN_TWO = routed[`IOPS_IN_CAP2];
  assign CAPTURE_IN_SEVEN = routed[`IOPS_IN_CAP7];
  assign CAPTURE_IN_EIGHT = routed[`IOPS_IN_CAP8];
  assign COMPARE_FAULT_IN = routed[`IOPS_IN_CFLT];
  assign SERIAL_RX_IN = routed[`IOPS_IN_SRX];
  assign SERIAL_CTS_IN = routed[`IOPS_IN_SCTS];
  assign SYNC_SERIAL_DATA_IN = routed[`IOPS_IN_SDI];
  assign SYNC_SERIAL_CLOCK_IN = routed[`IOPS_IN_SCK];
  assign SYNC_SERIAL_SELECT_IN = routed[`IOPS_IN_SSEL];

endmodule
`default_nettype wire

// *** core/iops_consts.vh ***
// constants for the io port pin select block: widths, reset values, codes
// assumes inclusion by the single design file only
`ifndef IOPS_CONSTS_VH
`define IOPS_CONSTS_VH
// ****************************************
// sizes
// ****************************************
`define IOPS_NPIN 26
`define IOPS_NCN 31
`define IOPS_NAN 13
`define IOPS_NIN 14
`define IOPS_SELW 5
// ****************************************
// reset values
// ****************************************
`define IOPS_ANCFG_RST 13'h0
`define IOPS_DIR_RST 26'h3ffffff
`define IOPS_LAT_RST 26'h0
`define IOPS_OD_RST 26'h0
`define IOPS_CNEN_RST 31'h0
`define IOPS_PU_RST 31'h0
`define IOPS_LVL_RST 26'h0
`define IOPS_CNLAST_RST 31'h0
`define IOPS_INSEL_RST 5'h1f
`define IOPS_OUTSEL_RST 5'h00
// ****************************************
// output codes
// ****************************************
`define IOPS_OC_NULL 5'h00
`define IOPS_OC_SER_TX 5'h03
`define IOPS_OC_SER_RTS 5'h04
`define IOPS_OC_SS_DO 5'h07
`define IOPS_OC_SS_CK 5'h08
`define IOPS_OC_SS_SEL 5'h09
`define IOPS_OC_CMP1 5'h12
`define IOPS_OC_CMP2 5'h13
// ****************************************
// input route indices
// ****************************************
`define IOPS_IN_EXT_IRQ_ONE 0
`define IOPS_IN_EXT_IRQ_TWO 1
`define IOPS_IN_TIMER_TWO_CLOCK_IN 2
`define IOPS_IN_TIMER_THREE_CLOCK_IN 3
`define IOPS_IN_CAP1 4
`define IOPS_IN_CAP2 5
`define IOPS_IN_CAP7 6
`define IOPS_IN_CAP8 7
`define IOPS_IN_CFLT 8
`define IOPS_IN_SRX 9
`define IOPS_IN_SCTS 10
`define IOPS_IN_SDI 11
`define IOPS_IN_SCK 12
`define IOPS_IN_SSEL 13
`endif

// *** tb/iops_pin_select_monitor.sv ***
// port assertions for the io port pin select block
// bound to the design; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module iops_pin_select_monitor (
  input wire SYS_CLK,
  input wire RST_N,
  input wire LATCH_WE, CNEN_WE, PU_WE, CHANGE_IRQ,
  input wire [25:0] LATCH_WDATA, PIN_IN, PIN_OUT, PIN_OE, OUTPUT_LATCH,
  input wire [25:0] PIN_DIRECTION, OPEN_DRAIN_SELECT, PIN_LEVEL,
  input wire [30:0] CNEN_WDATA, PU_WDATA, CHANGE_WATCH_INPUT, WEAK_PULLUP_EN, CHANGE_IRQ_ENABLE,
  input wire [12:0] ANALOG_PIN_CONFIG
);
  // ****
  // assertions
  // ****
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  reset_vals_a: assert property (!$past(RST_N) |->
    PIN_DIRECTION == 26'h3ffffff && ANALOG_PIN_CONFIG == 13'h0000) else $error("bad reset");
  od_low_only_a: assert property ((OPEN_DRAIN_SELECT & PIN_OE & PIN_OUT) == 26'h0)
    else $error("open drain high");
  in_undriven_a: assert property ((PIN_OE & PIN_DIRECTION) == 26'h0)
    else $error("input driven");
  latch_wr_a: assert property (LATCH_WE |=> OUTPUT_LATCH == $past(LATCH_WDATA))
    else $error("latch lost");
  cnen_wr_a: assert property (CNEN_WE |=> CHANGE_IRQ_ENABLE == $past(CNEN_WDATA))
    else $error("enable lost");
  pullup_wr_a: assert property (PU_WE |=> WEAK_PULLUP_EN == $past(PU_WDATA))
    else $error("pullup lost");
  level_samp_a: assert property ($past(RST_N) |->
    PIN_LEVEL[25:13] == $past(PIN_IN[25:13])) else $error("level stale");
  analog_zero_a: assert property ($stable(ANALOG_PIN_CONFIG) |->
    (PIN_LEVEL[12:0] & ~ANALOG_PIN_CONFIG) == 13'h0) else $error("analog reads high");
  irq_change_a: assert property ($past(RST_N) |-> CHANGE_IRQ ==
    |(CHANGE_IRQ_ENABLE & (CHANGE_WATCH_INPUT ^ $past(CHANGE_WATCH_INPUT))))
    else $error("bad change request");
  irq_c: cover property (CHANGE_IRQ);
  od_c: cover property (|(OPEN_DRAIN_SELECT & PIN_OE));
  lat_c: cover property (LATCH_WE);
endmodule
bind iops_pin_select iops_pin_select_monitor u_mon (.SYS_CLK, .RST_N, .LATCH_WE, .CNEN_WE,
  .PU_WE, .CHANGE_IRQ, .LATCH_WDATA, .PIN_IN, .PIN_OUT, .PIN_OE, .OUTPUT_LATCH, .PIN_DIRECTION,
  .OPEN_DRAIN_SELECT, .PIN_LEVEL, .CNEN_WDATA, .PU_WDATA, .CHANGE_WATCH_INPUT,
  .WEAK_PULLUP_EN, .CHANGE_IRQ_ENABLE, .ANALOG_PIN_CONFIG);
`default_nettype wire

// *** tb/iops_pad_model.sv ***
// pad ring and board: resolves pin and change-input levels
// board pull-ups on all remappable pads
`timescale 1ns/1ps
`default_nettype none
module iops_pad_model (
  input wire logic clk,
  input wire logic [25:0] pin_out, pin_oe, ext_val, ext_en,
  output logic [25:0] pin_in,
  input wire logic [30:0] pu_en, cn_val, cn_en,
  output logic [30:0] cn_in
);
  logic tgl = 1'b0;
  always @(posedge clk) tgl <= ~tgl;
  // undriven pad floats high, so open drain can only pull low
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
  // no pull-up: undriven input wanders so stale levels never pass
  assign cn_in = (cn_en & cn_val) | (~cn_en & (pu_en | {31{tgl}}));
endmodule
`default_nettype wire

// *** tb/iops_pin_select_tb.sv ***
// directed bench for the io port pin select block
// pads and board come from iops_pad_model
`timescale 1ns/1ps
`default_nettype none
module iops_pin_select_tb;
  logic SYS_CLK = 1'b0, RST_N = 1'b0, run = 1'b1;
  logic [30:0] wd = 31'h0, cn_val = 31'h0, cn_en = 31'h0;
  logic [7:0] we = 8'h00;
  logic [4:0] ix = 5'h00;
  logic [25:0] ext_val = 26'h0, ext_en = 26'h0;
  logic [6:0] pv = 7'h00;
  wire [25:0] pin_in, pin_out, pin_oe, lat, dir, ods, lvl;
  wire [30:0] cw, pu, cne;
  wire [12:0] anc;
  wire [13:0] ins;
  wire irq;
  int error_cnt = 0, cmp_count = 0, cyc = 0, i;
  localparam logic [25:0] LV = 26'h2aaaaaa;
  localparam logic [34:0] CODES = {5'h13, 5'h12, 5'h09, 5'h08, 5'h07, 5'h04, 5'h03};
  always #25 SYS_CLK = run ? ~SYS_CLK : SYS_CLK;
  iops_pad_model u_pad (.clk(SYS_CLK), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in), .pu_en(pu), .cn_val(cn_val), .cn_en(cn_en), .cn_in(cw));
  iops_pin_select DUT (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .LATCH_WDATA(wd[25:0]),
    .LATCH_WE(we[0]), .DIR_WDATA(wd[25:0]), .DIR_WE(we[1]), .ODSEL_WDATA(wd[25:0]),
    .ODSEL_WE(we[2]), .ANCFG_WDATA(wd[12:0]), .ANCFG_WE(we[3]), .CNEN_WDATA(wd),
    .CNEN_WE(we[4]), .PU_WDATA(wd), .PU_WE(we[5]), .OUTSEL_WDATA(wd[4:0]), .OUTSEL_IDX(ix),
    .OUTSEL_WE(we[6]), .INSEL_WDATA(wd[4:0]), .INSEL_IDX(ix[3:0]), .INSEL_WE(we[7]),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .CHANGE_WATCH_INPUT(cw),
    .WEAK_PULLUP_EN(pu), .CHANGE_IRQ(irq), .OUTPUT_LATCH(lat), .PIN_DIRECTION(dir),
    .OPEN_DRAIN_SELECT(ods), .ANALOG_PIN_CONFIG(anc), .CHANGE_IRQ_ENABLE(cne),
    .PIN_LEVEL(lvl), .SERIAL_TX_OUT(pv[0]), .SERIAL_RTS_OUT(pv[1]),
    .SYNC_SERIAL_DATA_OUT(pv[2]), .SYNC_SERIAL_CLOCK_OUT(pv[3]),
    .SYNC_SERIAL_SELECT_OUT(pv[4]), .COMPARE_OUT_ONE(pv[5]), .COMPARE_OUT_TWO(pv[6]),
    .EXT_IRQ_ONE(ins[0]), .EXT_IRQ_TWO(ins[1]), .TIMER_TWO_CLOCK_IN(ins[2]),
    .TIMER_THREE_CLOCK_IN(ins[3]), .CAPTURE_IN_ONE(ins[4]), .CAPTURE_IN_TWO(ins[5]),
    .CAPTURE_IN_SEVEN(ins[6]), .CAPTURE_IN_EIGHT(ins[7]), .COMPARE_FAULT_IN(ins[8]),
    .SERIAL_RX_IN(ins[9]), .SERIAL_CTS_IN(ins[10]), .SYNC_SERIAL_DATA_IN(ins[11]),
    .SYNC_SERIAL_CLOCK_IN(ins[12]), .SYNC_SERIAL_SELECT_IN(ins[13]));
  // ****
  // tasks
  // ****
  task automatic wr(input int k, input logic [30:0] d, input logic [4:0] x);
    @(posedge SYS_CLK);
    wd <= d; ix <= x; we <= 8'h01 << k;
    @(posedge SYS_CLK);
    we <= 8'h00;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a hang costs a mismatch; the full run needs about a hundred cycles
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict;
    end
  end
  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    #1;
    chk(dir, 26'h3ffffff);
    chk(anc, 13'h0000);
    chk(ins, 14'h0);
    $display("test reset done");
    wr(0, LV, 0);
    chk(lat, LV);
    wr(1, 31'h1fff, 0);
    chk(pin_oe, 26'h3ffe000);
    tick(2);
    chk(lvl, LV & 26'h3ffe000);
    wr(3, 31'h1fff, 0);
    wr(1, 31'h0, 0);
    chk(pin_oe, 26'h3ffffff);
    tick(2);
    chk(lvl, LV);
    $display("test port done");
    wr(2, 31'h3ffffff, 0);
    chk(ods, 26'h3ffffff);
    chk(pin_oe, ~LV & 26'h3ffffff);
    tick(2);
    chk(lvl, LV);
    wr(2, 31'h0, 0);
    $display("test open drain done");
    for (i = 0; i < 7; i++) wr(6, 31'(CODES[5*i +: 5]), 5'(i));
    wr(6, 31'h05, 7);
    for (i = 0; i < 2; i++) begin
      @(posedge SYS_CLK);
      pv <= i ? 7'h2b : 7'h54;
      #1;
      chk(pin_out[8:0], {LV[8:7], pv});
    end
    $display("test output map done");
    wr(1, 31'h3ffffff, 0);
    for (i = 0; i < 14; i++) wr(7, 31'(i + 12), 5'(i));
    for (i = 0; i < 2; i++) begin
      @(posedge SYS_CLK);
      ext_en <= 26'h3ffffff;
      ext_val <= i ? 26'h2a5c3f1 : 26'h15a3c0e;
      #1;
      chk(ins, ext_val[25:12]);
    end
    $display("test input map done");
    wr(5, 31'h7fffffff, 0);
    chk(pu, 31'h7fffffff);
    wr(4, 31'h40000000, 0);
    chk(cne, 31'h40000000);
    @(posedge SYS_CLK);
    cn_en <= 31'h7fffffff;
    cn_val <= 31'h7fffffff;
    @(posedge SYS_CLK);
    cn_val <= 31'h7ffffffe;
    #1;
    chk(irq, 1'b0);
    @(posedge SYS_CLK);
    cn_val <= 31'h3ffffffe;
    #1;
    chk(irq, 1'b1);
    tick(1);
    chk(irq, 1'b0);
    @(negedge SYS_CLK);
    run = 1'b0;
    cn_val <= 31'h7ffffffe;
    #210;
    chk(irq, 1'b1);
    run = 1'b1;
    tick(2);
    chk(irq, 1'b0);
    $display("test change done");
    give_verdict;
  end
endmodule
`default_nettype wire
